// file: src/wtseq_pkg.sv
// Shared constants and types of the waveform trigger sequencer.
// Assumes one sample per clk_sys_i rising edge while the clock enable is high.
package wtseq_pkg;

   // -----------------------------------------------------------------
   // Field widths
   // -----------------------------------------------------------------
   localparam int DELAY_W   = 23;  // Other-path delay in hundredths of a sample.
   localparam int INHIBIT_W = 26;  // Restart-inhibit count in samples.
   localparam int MARKER_W  = 20;  // Marker delay in samples.
   localparam int MARKER_N  = 4;   // Number of marker outputs.
   localparam int MSEL_W    = 2;   // Marker select width.
   localparam int ADDR_W    = 24;  // Playback sample address width.
   localparam int LAT_W     = 8;   // Processing latency counter width.

   // -----------------------------------------------------------------
   // Counts
   // -----------------------------------------------------------------
   localparam logic [LAT_W-1:0]   LATENCY_SAMPLES = 8'h10;       // Processing latency in samples.
   localparam logic [DELAY_W-1:0] DELAY_PER_SAMPLE = 23'h00_0064; // Hundredths per sample.

   // -----------------------------------------------------------------
   // Values after reset
   // -----------------------------------------------------------------
   localparam logic                 RST_ALIGNED = 1'b1;
   localparam logic                 RST_FIXED   = 1'b0;
   localparam logic [DELAY_W-1:0]   RST_DELAY   = 23'h00_0000;
   localparam logic [INHIBIT_W-1:0] RST_INHIBIT = 26'h000_0000;

   // -----------------------------------------------------------------
   // Modes, sources and states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_AUTO, MODE_RETRIG, MODE_ARM_AUTO, MODE_ARM_RETRIG} wtseq_mode_e;
   typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXTERNAL, SRC_OTHER_PATH, SRC_NONE} wtseq_src_e;
   typedef enum logic [1:0] {ST_WAIT, ST_LATENCY, ST_RUN} wtseq_state_e;

endpackage

// file: src/wtseq_core.sv
// Trigger sequencer for an arbitrary-waveform playback path.
// Assumes all inputs are synchronous to clk_sys_i and that strobes are one cycle long.
`timescale 1ns/100ps

// How it works
// RULE_01 - Stop-arm halts playback in armed modes.
// RULE_02 - Next trigger after stop restarts playback.
// RULE_03 - Software trigger needs internal source, non-auto.
// RULE_04 - Retrigger: each accepted trigger restarts from start.
// RULE_05 - Aligned output only with external source.
// RULE_06 - Aligned: generate at trigger, hide latency.
// RULE_07 - Unaligned: output after latency from sample zero.
// RULE_08 - Host disables alignment for short sequences.
// RULE_09 - Other-path trigger delayed by programmable samples.
// RULE_10 - Restart blocked for inhibit count after trigger.
// RULE_11 - Inhibit applies only to other-path source.
// RULE_12 - Fixed range limits marker delay to dynamic range.
// RULE_13 - Out-of-range marker delay clamped, error raised.
// RULE_14 - Fixed range covers all markers together.
// RULE_15 - Armed-auto starts on trigger, runs until stopped.
// RULE_16 - Armed-retrigger becomes retrigger after first trigger.
// RULE_17 - Other-path source uses second path's trigger.
// RULE_18 - Other-path triggers ignored while inhibit counter runs.
// RULE_19 - Reset: aligned on, fixed off, counts zero.
module wtseq_core
   import wtseq_pkg::*;
(
   input  wire logic                         clk_sys_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         clk_en_i,
   input  wire wtseq_mode_e                  mode_i,
   input  wire wtseq_src_e                   source_i,
   input  wire logic                         sw_trigger_i,
   input  wire logic                         stop_arm_i,
   input  wire logic                         ext_trigger_i,
   input  wire logic                         other_path_trig_i,
   input  wire logic                         cfg_wr_i,
   input  wire logic                         trigger_aligned_output_i,
   input  wire logic                         fixed_range_i,
   input  wire logic [DELAY_W-1:0]           other_path_delay_i,
   input  wire logic [INHIBIT_W-1:0]         other_path_inhibit_i,
   input  wire logic                         marker_wr_i,
   input  wire logic [MSEL_W-1:0]            marker_sel_i,
   input  wire logic [MARKER_W-1:0]          marker_delay_i,
   input  wire logic [MARKER_W-1:0]          marker_dyn_max_i,
   output logic                              playing_o,
   output logic                              restart_o,
   output logic                              sample_valid_o,
   output logic [ADDR_W-1:0]                 sample_addr_o,
   output logic                              delay_pending_o,
   output logic                              inhibit_busy_o,
   output logic [MARKER_N*MARKER_W-1:0]      marker_delay_o,
   output logic                              marker_err_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      wtseq_state_e                       st;
      logic                               retrig_active;
      logic                               gen_aligned;
      logic                               aligned;
      logic                               fixed;
      logic [DELAY_W-1:0]                 dly_cfg;
      logic [INHIBIT_W-1:0]               inh_cfg;
      logic                               dly_pend;
      logic [DELAY_W-1:0]                 dly_acc;
      logic [INHIBIT_W-1:0]               inh_cnt;
      logic [LAT_W-1:0]                   lat_cnt;
      logic [ADDR_W-1:0]                  addr;
      logic                               valid;
      logic                               restart;
      logic [MARKER_N-1:0][MARKER_W-1:0]  mk_dly;
      logic                               mk_err;
      logic                               play;
      logic                               busy;
   } wtseq_core_s;

   wtseq_core_s r;
   wtseq_core_s next_r;
   logic        sw_ok;
   logic        ext_ok;
   logic        oth_fire;
   logic        evt;
   logic        armed;

   // Event qualification per source; the inhibit gate only acts on the other path.
   always_comb begin
      // RULE_03 software gate
      sw_ok  = sw_trigger_i && (source_i == SRC_INTERNAL) && (mode_i != MODE_AUTO);
      ext_ok = ext_trigger_i && (source_i == SRC_EXTERNAL);
      // RULE_09 zero delay passes at once
      oth_fire = (source_i == SRC_OTHER_PATH) &&
                 ((r.dly_pend && ((r.dly_acc + DELAY_PER_SAMPLE) >= r.dly_cfg)) ||
                  (!r.dly_pend && other_path_trig_i && (r.dly_cfg == RST_DELAY)));
      // RULE_18 inhibit masks other-path events
      evt   = sw_ok || ext_ok || (oth_fire && (r.inh_cnt == RST_INHIBIT));
      armed = (mode_i == MODE_ARM_AUTO) || (mode_i == MODE_ARM_RETRIG);
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Computes the whole next state; the clock enable freezes it in the register stage.
   always_comb begin
      next_r         = r;
      next_r.restart = 1'b0;

      // RULE_19 configuration load
      if (cfg_wr_i) begin
         next_r.aligned = trigger_aligned_output_i;
         next_r.fixed   = fixed_range_i;
         next_r.dly_cfg = other_path_delay_i;
         next_r.inh_cfg = other_path_inhibit_i;
      end

      // RULE_17 second-path trigger delay
      if (source_i != SRC_OTHER_PATH || oth_fire) begin
         next_r.dly_pend = 1'b0;
      end else if (r.dly_pend) begin
         next_r.dly_acc = r.dly_acc + DELAY_PER_SAMPLE;
      end else if (other_path_trig_i) begin
         next_r.dly_pend = 1'b1;
         next_r.dly_acc  = RST_DELAY;
      end

      // RULE_10 inhibit countdown
      if (r.inh_cnt != RST_INHIBIT) begin
         next_r.inh_cnt = r.inh_cnt - 26'h000_0001;
      end
      // RULE_11 load only for other path
      if (evt && source_i == SRC_OTHER_PATH) begin
         next_r.inh_cnt = r.inh_cfg;
      end

      // Playback address and latency window advance.
      case (r.st)
         ST_LATENCY: begin
            if (r.gen_aligned) begin
               next_r.addr = r.addr + 24'h00_0001;
            end
            next_r.lat_cnt = r.lat_cnt + 8'h01;
            // RULE_06 RULE_07 latency elapsed
            if (r.lat_cnt == LATENCY_SAMPLES - 8'h01) begin
               next_r.st    = ST_RUN;
               next_r.valid = 1'b1;
            end
         end
         ST_RUN: begin
            next_r.addr = r.addr + 24'h00_0001;
         end
         default: begin
            next_r.valid = 1'b0;
         end
      endcase

      // Mode decisions; stop-arm takes priority over a trigger in the same cycle.
      if (armed && stop_arm_i) begin
         // RULE_01 halt and wait
         next_r.st            = ST_WAIT;
         next_r.valid         = 1'b0;
         next_r.retrig_active = 1'b0;
      end else begin
         case (mode_i)
            MODE_AUTO:       next_r.restart = (r.st == ST_WAIT);
            // RULE_04 every event restarts
            MODE_RETRIG:     next_r.restart = (r.st == ST_WAIT) || evt;
            // RULE_15 start on trigger only
            MODE_ARM_AUTO:   next_r.restart = (r.st == ST_WAIT) && evt;
            // RULE_16 switch to retrigger
            default:         next_r.restart = evt && ((r.st == ST_WAIT) || r.retrig_active);
         endcase
         if (mode_i == MODE_ARM_RETRIG && evt) begin
            next_r.retrig_active = 1'b1;
         end
      end

      // RULE_02 RULE_05 start from sample zero
      if (next_r.restart) begin
         next_r.st          = ST_LATENCY;
         next_r.lat_cnt     = 8'h00;
         next_r.addr        = 24'h00_0000;
         next_r.valid       = 1'b0;
         next_r.gen_aligned = r.aligned && (source_i == SRC_EXTERNAL);
      end

      // RULE_12 RULE_13 RULE_14 shared clamp
      if (marker_wr_i) begin
         if (r.fixed && (marker_delay_i > marker_dyn_max_i)) begin
            next_r.mk_dly[marker_sel_i] = marker_dyn_max_i;
            next_r.mk_err               = 1'b1;
         end else begin
            next_r.mk_dly[marker_sel_i] = marker_delay_i;
            next_r.mk_err               = 1'b0;
         end
      end

      // Status levels are registered copies, so the ports come straight from flip-flops.
      next_r.play = (next_r.st != ST_WAIT);
      next_r.busy = (next_r.inh_cnt != RST_INHIBIT);
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // Reset loads defaults; a low clock enable holds everything.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         r         <= '0;
         r.aligned <= RST_ALIGNED;
         r.fixed   <= RST_FIXED;
         r.dly_cfg <= RST_DELAY;
         r.inh_cfg <= RST_INHIBIT;
      end else if (clk_en_i) begin
         r <= next_r;
      end
   end

   // Outputs taken straight from the state register.
   assign playing_o       = r.play;
   assign restart_o       = r.restart;
   assign sample_valid_o  = r.valid;
   assign sample_addr_o   = r.addr;
   assign delay_pending_o = r.dly_pend;
   assign inhibit_busy_o  = r.busy;
   assign marker_delay_o  = r.mk_dly;
   assign marker_err_o    = r.mk_err;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_stop_req;
      clk_en_i && armed && stop_arm_i;
   endsequence

   sequence s_wait_trig;
      clk_en_i && armed && !stop_arm_i && r.st == ST_WAIT && evt;
   endsequence

   a_stop_halts: assert property (s_stop_req |=> r.st == ST_WAIT && !r.valid) // RULE_01
      else $error("stop-arm did not halt playback");

   a_arm_restart: assert property (s_wait_trig |=> r.restart && r.st == ST_LATENCY && r.addr == '0) // RULE_02
      else $error("trigger after stop did not restart");

   a_sw_gate: assert property (sw_trigger_i && source_i != SRC_INTERNAL && !ext_ok && !oth_fire |-> !evt) // RULE_03
      else $error("software trigger accepted with wrong source");

   a_retrig_start: assert property (clk_en_i && mode_i == MODE_RETRIG && evt |=> r.restart && r.addr == '0) // RULE_04
      else $error("retrigger did not restart from start");

   a_aligned_start: assert property ($rose(r.valid) && r.gen_aligned |->
      r.addr == ADDR_W'(LATENCY_SAMPLES) && $past(r.lat_cnt) == LATENCY_SAMPLES - 8'h01) // RULE_06
      else $error("aligned output not at latency offset");

   a_full_start: assert property ($rose(r.valid) && !r.gen_aligned |->
      r.addr == '0 && $past(r.lat_cnt) == LATENCY_SAMPLES - 8'h01) // RULE_07
      else $error("unaligned output not at sample zero");

   a_inhibit_block: assert property (r.inh_cnt != '0 && source_i == SRC_OTHER_PATH |-> !evt) // RULE_18
      else $error("trigger accepted during inhibit");

   a_inhibit_other: assert property (clk_en_i && evt && source_i != SRC_OTHER_PATH && r.inh_cnt == '0
      |=> r.inh_cnt == '0) // RULE_11
      else $error("inhibit loaded for non-other source");

   a_marker_clamp: assert property (clk_en_i && marker_wr_i && r.fixed && marker_delay_i > marker_dyn_max_i
      |=> r.mk_dly[$past(marker_sel_i)] == $past(marker_dyn_max_i) && r.mk_err) // RULE_13
      else $error("marker delay not clamped");

   a_auto_hold: assert property (clk_en_i && mode_i == MODE_ARM_AUTO && r.st == ST_RUN && !stop_arm_i
      |=> !r.restart && r.st == ST_RUN) // RULE_15
      else $error("armed-auto restarted while running");

endmodule

// file: test/wtseq_far_model.sv
// Far-side model of the sequencer: external trigger connector and second signal path.
// Assumes callers enter its task just after a falling edge of clk_sys_i.
`timescale 1ns/100ps
module wtseq_far_model (
   input  wire logic clk_sys_i,
   output logic      ext_trigger_o,
   output logic      other_path_trig_o
);
   // Both trigger lines rest low between events.
   initial begin
      ext_trigger_o     = 1'b0;
      other_path_trig_o = 1'b0;
   end

   // Sends one event, one clock wide, launched and dropped on falling edges.
   task automatic fire(input logic other);
      if (other) begin
         other_path_trig_o = 1'b1;
      end else begin
         ext_trigger_o = 1'b1;
      end
      @(negedge clk_sys_i);
      other_path_trig_o = 1'b0;
      ext_trigger_o     = 1'b0;
   endtask
endmodule

// file: test/waveform_trigger_sequencer_tb.sv
// Self-checking bench of the trigger sequencer core.
// Assumes the far-side model drives the trigger lines; inputs change on falling edges.
`timescale 1ns/100ps
module waveform_trigger_sequencer_tb;
   import wtseq_pkg::*;
   logic                        clk_sys_i, sys_rst_i, sw_trig, stop_arm, cfg_wr, aligned, fixed, marker_wr;
   logic                        ext_trig, other_trig, playing, restart, valid, pending, busy, merr, clk_en;
   wtseq_mode_e                 mode;
   wtseq_src_e                  src;
   logic [DELAY_W-1:0]          delay;
   logic [INHIBIT_W-1:0]        inhibit;
   logic [MSEL_W-1:0]           msel;
   logic [MARKER_W-1:0]         mdelay, mmax;
   logic [ADDR_W-1:0]           addr;
   logic [MARKER_N*MARKER_W-1:0] markers;
   int                          bad_count, num_checks, cycles, n;

   // Design and far side.
   wtseq_core i_wtseq_core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
      .mode_i(mode), .source_i(src), .sw_trigger_i(sw_trig), .stop_arm_i(stop_arm),
      .ext_trigger_i(ext_trig), .other_path_trig_i(other_trig), .cfg_wr_i(cfg_wr),
      .trigger_aligned_output_i(aligned), .fixed_range_i(fixed), .other_path_delay_i(delay),
      .other_path_inhibit_i(inhibit), .marker_wr_i(marker_wr), .marker_sel_i(msel),
      .marker_delay_i(mdelay), .marker_dyn_max_i(mmax), .playing_o(playing), .restart_o(restart),
      .sample_valid_o(valid), .sample_addr_o(addr), .delay_pending_o(pending),
      .inhibit_busy_o(busy), .marker_delay_o(markers), .marker_err_o(merr));
   wtseq_far_model i_wtseq_far_model (.clk_sys_i(clk_sys_i), .ext_trigger_o(ext_trig),
      .other_path_trig_o(other_trig));

   // ------------------------------------------------------------
   // Clock, timeout and closing report
   // ------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // A hang past the expected run length counts as a mismatch.
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask
   // Drives only the selected strobe, so the other strobes are never touched twice in one step.
   task automatic set_strobe(input int which, input logic v);
      case (which)
         0: sw_trig = v;
         1: stop_arm = v;
         2: cfg_wr = v;
         default: marker_wr = v;
      endcase
   endtask
   // Strobes 0 software trigger, 1 stop-arm, 2 config, 3 marker, 4 external, 5 second path.
   task automatic pulse(input int which);
      if (which > 3) begin
         i_wtseq_far_model.fire(which == 5);
      end else begin
         set_strobe(which, 1'b1);
         @(negedge clk_sys_i);
         set_strobe(which, 1'b0);
      end
   endtask
   // Counts falling edges until a restart shows.
   task automatic wait_rs(input int exp);
      n = 0;
      while (restart !== 1'b1 && n < 40) begin
         @(negedge clk_sys_i);
         n++;
      end
      check("restart wait", 32'(n), 32'(exp));
   endtask
   task automatic mark(input int s, input logic [MARKER_W-1:0] r, e, input logic er);
      msel   = MSEL_W'(s);
      mdelay = r;
      pulse(3);
      check("marker", 32'(markers[s*MARKER_W +: MARKER_W]), 32'(e));
      check("marker_err", 32'(merr), 32'(er));
      step(1);
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {sys_rst_i, sw_trig, stop_arm, cfg_wr, aligned, fixed, marker_wr} = 7'h40;
      {delay, inhibit, msel, mdelay} = '0;
      clk_en = 1'b1;
      mmax = 20'h0_0064;
      mode = MODE_ARM_AUTO;
      src  = SRC_INTERNAL;
      step(8);
      sys_rst_i = 1'b0;
      check("idle", 32'({restart, playing, valid, pending, busy, merr, |addr, |markers}), 32'h0000_0000);
      // Host selects internal source and an armed mode before triggering.
      pulse(0);
      check("start", 32'({restart, playing}), 32'h0000_0003);
      step(16);
      check("unaligned", 32'({valid, addr}), 32'h0100_0000);
      pulse(0);
      check("rearm", 32'(restart), 32'h0000_0000);
      pulse(1);
      check("stopped", 32'(playing), 32'h0000_0000);
      pulse(0);
      check("restart", 32'(restart), 32'h0000_0001);
      // Stopped and waiting, so only the source gate can refuse the software trigger.
      {mode, src} = {MODE_ARM_RETRIG, SRC_EXTERNAL};
      pulse(1);
      pulse(0);
      check("sw refused", 32'(restart), 32'h0000_0000);
      pulse(4);
      check("ext start", 32'(restart), 32'h0000_0001);
      step(16);
      check("aligned", 32'({valid, addr}), 32'h0100_0010);
      pulse(4);
      check("retrig", 32'({restart, addr}), 32'h0100_0000);
      // Host runs unaligned for the short bursts that follow.
      {mode, src, aligned, fixed} = {MODE_RETRIG, SRC_OTHER_PATH, 2'h1};
      {delay, inhibit} = {23'h00_00fa, 26'h000_0005};
      pulse(2);
      pulse(5);
      check("pending", 32'(pending), 32'h0000_0001);
      wait_rs(3);
      step(8);
      delay = '0;
      pulse(2);
      pulse(5);
      wait_rs(0);
      check("busy", 32'(busy), 32'h0000_0001);
      step(1);
      pulse(5);
      check("inhibited", 32'(restart), 32'h0000_0000);
      step(6);
      check("busy over", 32'(busy), 32'h0000_0000);
      pulse(5);
      wait_rs(0);
      src = SRC_INTERNAL;
      pulse(0);
      step(1);
      pulse(0);
      check("no inhibit", 32'(restart), 32'h0000_0001);
      mark(2, 20'h0_00c8, 20'h0_0064, 1'b1);
      mark(1, 20'h0_0032, 20'h0_0032, 1'b0);
      mark(3, 20'h0_012c, 20'h0_0064, 1'b1);
      fixed = 1'b0;
      pulse(2);
      mark(0, 20'h0_00c8, 20'h0_00c8, 1'b0);
      // A low clock enable freezes the sequencer at the start of the latency window, with restart still high.
      pulse(0);
      clk_en = 1'b0;
      step(20);
      check("frozen", 32'({restart, valid, addr}), 32'h0200_0000);
      clk_en = 1'b1;
      step(16);
      check("thawed", 32'({restart, valid, addr}), 32'h0100_0000);
      // Free-running mode starts by itself once stopped playback is left waiting.
      mode = MODE_ARM_AUTO;
      pulse(1);
      check("auto stop", 32'(playing), 32'h0000_0000);
      mode = MODE_AUTO;
      step(1);
      check("auto start", 32'(restart), 32'h0000_0001);
      pulse(0);
      check("auto sw", 32'(restart), 32'h0000_0000);
      end_sim();
   end
endmodule
